//--- include/blc_pkg.sv
// constants, register map and types of the bitstream load controller
// assumes one 50 MHz clock, a serial read flash and a byte-wide config sram port
// Overview of operation
// - both boot modes copy the bitstream from flash to config sram at 2.500 MHz unless another rate is set.
// - device group 0 divides a 250 MHz source by an even 2..46, or by 100 for the default rate.
// - device group 1 divides a 240 MHz source by an even 2..96, 96 being the default.
// - device group 2 divides a 200 MHz source by an even 2..128, 80 being the default.
// - with completion bypass on, the completion pin stays driven low once loading completes.
// - with power-on clearing on, the first load after reset zeroes all config sram and holds used i/o weak-high before configuring.
// - wake-up mode 0 starts operation after loading whatever level the completion pin has.
// - wake-up mode 1 with the completion pin high starts operation right after loading.
// - wake-up mode 1 with the pin low stays dormant until the pin is released high and tck pulses arrive.
// - secure mode turns the jtag pins into gpio and allows only one programming.
// - the flash read starts at the configured start address, zero by default.
// - a user code taken from the bitstream is held for the programmer to compare, zero by default.
package blc_pkg;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_DIV = 8'h04;
  localparam logic [7:0] REG_ADDR = 8'h08;
  localparam logic [7:0] REG_LEN = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_UCODE = 8'h14;
  // control register fields
  localparam int CTRL_START = 0;
  localparam int CTRL_MODE = 1;
  localparam int CTRL_GRP_LO = 2;
  localparam int CTRL_BYPASS = 4;
  localparam int CTRL_POR = 5;
  localparam int CTRL_WAKE = 6;
  localparam int CTRL_SECURE = 7;
  localparam logic [1:0] GRP_250 = 2'h0;
  localparam logic [1:0] GRP_240 = 2'h1;
  localparam logic [1:0] GRP_200 = 2'h2;
  localparam logic [7:0] DIV_MIN = 8'h02;
  localparam logic [7:0] DIV_MAX_250 = 8'h2E;
  localparam logic [7:0] DIV_MAX_240 = 8'h60;
  localparam logic [7:0] DIV_MAX_200 = 8'h80;
  localparam logic [7:0] DIV_DEF_250 = 8'h64;
  localparam logic [7:0] DIV_DEF_240 = 8'h60;
  localparam logic [7:0] DIV_DEF_200 = 8'h50;
  localparam logic [7:0] FLASH_READ_CMD = 8'h03;
  localparam logic [23:0] ADDR_RESET = 24'h000000;
  localparam logic [31:0] UCODE_RESET = 32'h00000000;
  localparam logic [5:0] CMD_BITS = 6'h20;
  localparam logic [5:0] BYTE_BITS = 6'h08;
  localparam logic [23:0] UCODE_BYTES = 24'h000004;
  localparam logic [15:0] CFG_WORDS = 16'h0400;
  localparam logic [2:0] WAKE_TCK_PULSES = 3'h4;
  typedef enum logic [2:0] {
    BLC_IDLE = 3'b000,
    BLC_CLEAR = 3'b001,
    BLC_CMD = 3'b010,
    BLC_DATA = 3'b011,
    BLC_FINISH = 3'b100,
    BLC_WAKE = 3'b101,
    BLC_RUN = 3'b110
  } blc_state_t;
endpackage

//--- verilog/blc_loader.sv
// bitstream load controller: flash to config sram copy, completion pin and wake-up
// assumes synchronous inputs, open-drain completion pin resolved outside, flash in read mode 0
//
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module blc_loader
  import blc_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic flash_sck,
  output logic flash_cs_n,
  output logic flash_mosi,
  input wire logic flash_miso,
  output logic cfg_wr,
  output logic [15:0] cfg_addr,
  output logic [7:0] cfg_data,
  input wire logic done_in,
  output logic done_out,
  output logic done_oe_n,
  input wire logic tck_in,
  output logic user_mode,
  output logic io_hold,
  output logic jtag_gpio,
  output logic busy
);
  typedef struct packed {
    blc_state_t st;
    logic [1:0] grp;
    logic boot_mode;
    logic bypass;
    logic por_en;
    logic wake_mode;
    logic secure_en;
    logic [7:0] div;
    logic [7:0] act_div;
    logic [6:0] half_cnt;
    logic [23:0] faddr;
    logic [23:0] flen;
    logic sck;
    logic cs_n;
    logic mosi;
    logic [31:0] sh_out;
    logic [7:0] sh_in;
    logic [5:0] bit_cnt;
    logic [23:0] byte_cnt;
    logic [15:0] cfg_addr;
    logic [7:0] cfg_data;
    logic cfg_wr;
    logic [31:0] ucode;
    logic cleared;
    logic io_hold;
    logic done_drive;
    logic done_lvl;
    logic loaded;
    logic awake;
    logic locked;
    logic refused;
    logic jtag_gpio;
    logic busy;
    logic tck_prev;
    logic first_wake;
    logic [2:0] tck_cnt;
    logic [31:0] rdata;
  } blc_reg_t;

  blc_reg_t r;
  blc_reg_t next_r;

  function automatic logic div_legal(input logic [1:0] g, input logic [7:0] d);
    logic [7:0] lim;
    lim = (g == GRP_240) ? DIV_MAX_240 : (g == GRP_200) ? DIV_MAX_200 : DIV_MAX_250;
    return !d[0] && d >= DIV_MIN && d <= lim;
  endfunction

  // zero or an illegal value for the group falls back to the 2.500 MHz divisor
  function automatic logic [7:0] div_eff(input logic [1:0] g, input logic [7:0] d);
    logic [7:0] def;
    def = (g == GRP_240) ? DIV_DEF_240 : (g == GRP_200) ? DIV_DEF_200 : DIV_DEF_250;
    return div_legal(g, d) ? d : def;
  endfunction

  logic idle;
  logic tick;
  logic [7:0] new_byte;
  assign idle = (r.st == BLC_IDLE) || (r.st == BLC_RUN);
  // half period in clk cycles; every divisor is even so both phases match
  assign tick = (r.half_cnt == (r.act_div[7:1] - 7'h01));
  assign new_byte = {r.sh_in[6:0], flash_miso};

  always_comb begin
    next_r = r;
    next_r.rdata = '0;
    next_r.cfg_wr = 1'b0;
    next_r.tck_prev = tck_in;
    // register writes
    if (reg_wr) begin
      case (reg_addr)
        REG_CTRL: begin
          // a start while dormant after a secure load is refused as well
          if (!idle && r.locked && reg_wdata[CTRL_START]) begin
            next_r.refused = 1'b1;
          end
          if (idle) begin
            next_r.boot_mode = reg_wdata[CTRL_MODE];
            next_r.grp = reg_wdata[CTRL_GRP_LO +: 2];
            next_r.bypass = reg_wdata[CTRL_BYPASS];
            next_r.por_en = reg_wdata[CTRL_POR];
            next_r.wake_mode = reg_wdata[CTRL_WAKE];
            next_r.secure_en = r.secure_en | reg_wdata[CTRL_SECURE];
            if (reg_wdata[CTRL_START]) begin
              if (r.locked) begin
                next_r.refused = 1'b1;
              end else begin
                next_r.act_div = div_eff(reg_wdata[CTRL_GRP_LO +: 2], r.div);
                next_r.half_cnt = '0;
                next_r.byte_cnt = '0;
                next_r.bit_cnt = '0;
                next_r.ucode = UCODE_RESET;
                next_r.loaded = 1'b0;
                next_r.awake = 1'b0;
                next_r.busy = 1'b1;
                next_r.done_drive = 1'b1;
                next_r.tck_cnt = '0;
                next_r.sh_out = {FLASH_READ_CMD, r.faddr};
                if (reg_wdata[CTRL_POR] && !r.cleared) begin
                  next_r.st = BLC_CLEAR;
                  next_r.io_hold = 1'b1;
                  next_r.cfg_addr = '0;
                end else begin
                  next_r.st = BLC_CMD;
                  next_r.cs_n = 1'b0;
                  next_r.mosi = FLASH_READ_CMD[7];
                end
              end
            end
          end
        end
        REG_DIV: begin
          // ignored mid-load and when neither zero nor a legal divisor for the group
          if (idle && (div_legal(r.grp, reg_wdata[7:0]) || reg_wdata[7:0] == 8'h00)) begin
            next_r.div = reg_wdata[7:0];
          end
        end
        REG_ADDR: begin
          if (idle) begin
            next_r.faddr = reg_wdata[23:0];
          end
        end
        REG_LEN: begin
          if (idle) begin
            next_r.flen = reg_wdata[23:0];
          end
        end
        default: begin
        end
      endcase
    end
    // register reads, valid the following cycle only
    if (reg_rd) begin
      case (reg_addr)
        REG_CTRL: next_r.rdata = {24'h000000, r.secure_en, r.wake_mode, r.por_en, r.bypass, r.grp,
                                  r.boot_mode, 1'b0};
        REG_DIV: next_r.rdata = {24'h000000, div_eff(r.grp, r.div)};
        REG_ADDR: next_r.rdata = {8'h00, r.faddr};
        REG_LEN: next_r.rdata = {8'h00, r.flen};
        REG_STATUS: next_r.rdata = {24'h000000, r.io_hold, r.refused, r.locked, r.awake, r.loaded,
                                    done_in, r.done_drive, r.busy};
        REG_UCODE: next_r.rdata = r.ucode;
        default: next_r.rdata = '0;
      endcase
    end
    // load sequencing
    case (r.st)
      BLC_IDLE: begin
      end
      BLC_CLEAR: begin
        // leave once the last word is out; one spare cycle, but no write past the array
        if (r.cfg_wr && r.cfg_addr == CFG_WORDS - 16'h0001) begin
          next_r.cleared = 1'b1;
          next_r.st = BLC_CMD;
          next_r.cs_n = 1'b0;
          next_r.mosi = FLASH_READ_CMD[7];
        end else begin
          next_r.cfg_wr = 1'b1;
          next_r.cfg_data = '0;
          next_r.cfg_addr = r.cfg_wr ? r.cfg_addr + 16'h0001 : 16'h0000;
        end
      end
      BLC_CMD, BLC_DATA: begin
        next_r.half_cnt = tick ? 7'h00 : r.half_cnt + 7'h01;
        if (tick) begin
          next_r.sck = ~r.sck;
          if (!r.sck) begin
            // rising edge: flash output sampled
            next_r.bit_cnt = r.bit_cnt + 6'h01;
            if (r.st == BLC_DATA) begin
              next_r.sh_in = new_byte;
              if (r.bit_cnt == BYTE_BITS - 6'h01) begin
                next_r.bit_cnt = '0;
                next_r.byte_cnt = r.byte_cnt + 24'h000001;
                if (r.byte_cnt < UCODE_BYTES) begin
                  next_r.ucode = {r.ucode[23:0], new_byte};
                end else begin
                  next_r.cfg_wr = 1'b1;
                  next_r.cfg_data = new_byte;
                  next_r.cfg_addr = 16'(r.byte_cnt - UCODE_BYTES);
                end
                if (r.byte_cnt + 24'h000001 == r.flen) begin
                  next_r.st = BLC_FINISH;
                end
              end
            end
          end else begin
            // falling edge: next command bit presented
            next_r.sh_out = {r.sh_out[30:0], 1'b0};
            next_r.mosi = r.sh_out[30];
            if (r.st == BLC_CMD && r.bit_cnt == CMD_BITS) begin
              next_r.bit_cnt = '0;
              next_r.mosi = 1'b0;
              if (r.flen == 24'h000000) begin
                next_r.st = BLC_FINISH;
              end else begin
                next_r.st = BLC_DATA;
              end
            end
          end
        end
      end
      BLC_FINISH: begin
        next_r.sck = 1'b0;
        next_r.cs_n = 1'b1;
        next_r.half_cnt = '0;
        next_r.loaded = 1'b1;
        next_r.busy = 1'b0;
        next_r.done_drive = r.bypass;
        if (r.secure_en) begin
          next_r.locked = 1'b1;
          next_r.jtag_gpio = 1'b1;
        end
        if (!r.wake_mode) begin
          next_r.st = BLC_RUN;
          next_r.awake = 1'b1;
          next_r.io_hold = 1'b0;
        end else begin
          // own drive still holds the pin here; its outside level shows one cycle later
          next_r.st = BLC_WAKE;
          next_r.first_wake = 1'b1;
        end
      end
      BLC_WAKE: begin
        // pin high at the first look wakes at once; otherwise release plus tck pulses
        next_r.first_wake = 1'b0;
        if (r.first_wake && done_in) begin
          next_r.st = BLC_RUN;
          next_r.awake = 1'b1;
          next_r.io_hold = 1'b0;
        end else if (!done_in) begin
          next_r.tck_cnt = '0;
        end else if (tck_in && !r.tck_prev) begin
          next_r.tck_cnt = r.tck_cnt + 3'h1;
          if (r.tck_cnt == WAKE_TCK_PULSES - 3'h1) begin
            next_r.st = BLC_RUN;
            next_r.awake = 1'b1;
            next_r.io_hold = 1'b0;
          end
        end
      end
      BLC_RUN: begin
      end
      default: begin
        next_r.st = BLC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r <= '0;
      r.st <= BLC_IDLE;
      r.cs_n <= 1'b1;
      r.faddr <= ADDR_RESET;
      r.ucode <= UCODE_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign reg_rdata = r.rdata;
  assign flash_sck = r.sck;
  assign flash_cs_n = r.cs_n;
  assign flash_mosi = r.mosi;
  assign cfg_wr = r.cfg_wr;
  assign cfg_addr = r.cfg_addr;
  assign cfg_data = r.cfg_data;
  assign done_out = r.done_lvl;
  assign done_oe_n = ~r.done_drive;
  assign user_mode = r.awake;
  assign io_hold = r.io_hold;
  assign jtag_gpio = r.jtag_gpio;
  assign busy = r.busy;

  a_bypass_holds_low: assert property (@(posedge clk) disable iff (sys_rst)
    (r.st == BLC_FINISH && r.bypass) |=> !done_oe_n [*2])
    else $error("completion pin released under bypass");
  a_div_stable_busy: assert property (@(posedge clk) disable iff (sys_rst)
    (r.busy && $past(r.busy)) |-> $stable(r.act_div))
    else $error("divisor changed during load");
  a_sck_half_period: assert property (@(posedge clk) disable iff (sys_rst)
    ($changed(flash_sck) && !flash_cs_n && r.st != BLC_FINISH) |-> $past(r.half_cnt) == $past(r.act_div[7:1]) - 7'h01)
    else $error("load clock phase not half the divisor");
  a_default_rate_grp0: assert property (@(posedge clk) disable iff (sys_rst)
    (reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_START] && idle && !r.locked
     && reg_wdata[CTRL_GRP_LO +: 2] == GRP_250 && r.div == 8'h00) |=> r.act_div == DIV_DEF_250)
    else $error("default divisor not applied");
  a_mode0_runs: assert property (@(posedge clk) disable iff (sys_rst)
    (r.st == BLC_FINISH && !r.wake_mode) |=> (user_mode && r.st == BLC_RUN))
    else $error("mode 0 did not start");
  a_mode1_high_runs: assert property (@(posedge clk) disable iff (sys_rst)
    (r.st == BLC_WAKE && r.first_wake && done_in) |=> user_mode)
    else $error("mode 1 with pin high did not start");
  a_mode1_low_sleeps: assert property (@(posedge clk) disable iff (sys_rst)
    (r.st == BLC_WAKE && r.first_wake && !done_in) |=> !user_mode ##1 !user_mode)
    else $error("mode 1 with pin low woke early");
  a_secure_refuse: assert property (@(posedge clk) disable iff (sys_rst)
    (r.locked && reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_START]) |=> (r.refused && !busy && jtag_gpio))
    else $error("second programming accepted");
  a_clear_zeroes: assert property (@(posedge clk) disable iff (sys_rst)
    ($past(r.st) == BLC_CLEAR && r.cfg_wr) |-> (cfg_data == 8'h00 && io_hold))
    else $error("clearing wrote nonzero data");
  a_cmd_address: assert property (@(posedge clk) disable iff (sys_rst)
    (r.st == BLC_CMD && $past(r.st) != BLC_CMD && r.bit_cnt == 6'h00) |-> r.sh_out == {FLASH_READ_CMD, r.faddr})
    else $error("flash read not aimed at start address");
  a_run_io_free: assert property (@(posedge clk) disable iff (sys_rst)
    (r.st == BLC_RUN) |-> !io_hold)
    else $error("i/o still held in operation");
  a_clear_in_range: assert property (@(posedge clk) disable iff (sys_rst)
    ($past(r.st) == BLC_CLEAR && cfg_wr) |-> cfg_addr < CFG_WORDS)
    else $error("clearing ran past the config sram");
endmodule

//--- verification/blc_flash_model.sv
// serial read flash model: command byte, 24-bit address, then data bytes MSB first
// assumes mode 0 timing; data byte is the low address byte xor 5A
`timescale 1ns/1ps
module blc_flash_model (
  input wire logic flash_sck,
  input wire logic flash_cs_n,
  input wire logic flash_mosi,
  output logic flash_miso,
  output logic cmd_err
);
  logic [31:0] cmd = 32'h0;
  logic [7:0] b;
  logic bit_q = 1'b0;
  int cnt = 0;
  int k;
  initial cmd_err = 1'b0;
  always @(posedge flash_sck or posedge flash_cs_n) begin
    if (flash_cs_n) begin
      cnt = 0;
    end else begin
      if (cnt < 32) cmd = {cmd[30:0], flash_mosi};
      if (cnt == 31 && cmd[31:24] !== 8'h03) cmd_err = 1'b1;
      cnt = cnt + 1;
    end
  end
  // data changes on falling sck so it is steady at the next rise
  always @(negedge flash_sck) begin
    if (!flash_cs_n && cnt >= 32) begin
      k = cnt - 32;
      b = (cmd[7:0] + 8'(k / 8)) ^ 8'h5A;
      bit_q = b[7 - (k % 8)];
    end
  end
  // deselected line shows the inverse so a stale sample cannot pass
  assign flash_miso = flash_cs_n ? ~bit_q : bit_q;
endmodule

//--- verification/tb.sv
// self-checking bench for the bitstream load controller
// assumes the flash model and a bench-controlled pull on the completion pin
`timescale 1ns/1ps
module tb;
  import blc_pkg::*;
  logic clk, sys_rst, reg_wr, reg_rd, tck_in, pull, sq, rose;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd;
  logic flash_sck, flash_cs_n, flash_mosi, flash_miso, cmd_err;
  logic cfg_wr, done_out, done_oe_n, user_mode, io_hold, jtag_gpio, busy;
  logic [15:0] cfg_addr;
  logic [7:0] cfg_data;
  logic [7:0] seen [4];
  logic [7:0] defs [3] = '{DIV_DEF_250, DIV_DEF_240, DIV_DEF_200};
  logic [7:0] maxs [3] = '{DIV_MAX_250, DIV_MAX_240, DIV_MAX_200};
  localparam logic [23:0] A = 24'h000100;
  wire done_in = done_oe_n ? pull : done_out;
  int mismatches, n_compared, exp_per, cnt, nclr, g;
  blc_loader blc_loader_inst (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_sck(flash_sck), .flash_cs_n(flash_cs_n),
    .flash_mosi(flash_mosi), .flash_miso(flash_miso), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
    .cfg_data(cfg_data), .done_in(done_in), .done_out(done_out), .done_oe_n(done_oe_n), .tck_in(tck_in),
    .user_mode(user_mode), .io_hold(io_hold), .jtag_gpio(jtag_gpio), .busy(busy));
  blc_flash_model blc_flash_model_inst (.flash_sck(flash_sck), .flash_cs_n(flash_cs_n),
    .flash_mosi(flash_mosi), .flash_miso(flash_miso), .cmd_err(cmd_err));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  function automatic logic [7:0] fb(input logic [23:0] a);
    return a[7:0] ^ 8'h5A;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdt(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    rdt(a);
    chk(rd, e);
  endtask
  task automatic rst;
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
  endtask
  // bound covers clearing plus a full load at the slowest divisor used here
  task automatic load(input logic [31:0] c);
    int n;
    n = 0;
    wr(REG_CTRL, c | 32'h1);
    repeat (3) @(negedge clk);
    chk(32'(busy), 32'h1);
    while (flash_cs_n !== 1'b0 && n < 20000) begin
      @(negedge clk);
      n++;
    end
    while (flash_cs_n !== 1'b1 && n < 20000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 20000) begin
      mismatches++;
      report_and_stop();
    end
    repeat (3) @(negedge clk);
  endtask
  task automatic chkd(input logic [23:0] a);
    for (int i = 0; i < 4; i++) chk(32'(seen[i]), 32'(fb(a + 24'(4 + i))));
    chk(32'(cmd_err), 32'h0);
  endtask
  task automatic tck_pulse(input int n);
    repeat (n) begin
      @(posedge clk);
      tck_in <= 1'b1;
      repeat (2) @(posedge clk);
      tck_in <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask
  // sampled on the falling clk edge, away from the design's updates
  always @(negedge clk) begin
    rose = flash_sck && !sq;
    sq = flash_sck;
    if (cfg_wr === 1'b1 && io_hold === 1'b1 && cfg_data === 8'h00) nclr++;
    else if (cfg_wr === 1'b1) seen[cfg_addr[1:0]] = cfg_data;
    if (flash_cs_n !== 1'b0) cnt = 0;
    else if (rose) begin
      if (cnt > 0) chk(32'(cnt), 32'(exp_per));
      cnt = 1;
    end else if (cnt > 0) cnt++;
  end
  initial begin
    sys_rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    tck_in = 1'b0;
    pull = 1'b0;
    sq = 1'b0;
    mismatches = 0;
    n_compared = 0;
    cnt = 0;
    nclr = 0;
    exp_per = 100;
    rst();
    rdc(REG_STATUS, 32'h0);
    rdc(REG_ADDR, 32'h0);
    rdc(REG_UCODE, 32'h0);
    rdc(8'h20, 32'h0);
    rdc(REG_DIV, 32'(DIV_DEF_250));
    $display("test reset values done");
    for (g = 0; g < 3; g++) begin
      wr(REG_CTRL, 32'(g) << CTRL_GRP_LO);
      wr(REG_DIV, 32'h0);
      rdc(REG_DIV, 32'(defs[g]));
      wr(REG_DIV, 32'(maxs[g]));
      rdc(REG_DIV, 32'(maxs[g]));
      wr(REG_DIV, 32'(maxs[g]) + 32'h2);
      rdc(REG_DIV, 32'(maxs[g]));
      wr(REG_DIV, 32'(DIV_MIN));
      wr(REG_DIV, 32'h3);
      rdc(REG_DIV, 32'(DIV_MIN));
    end
    $display("test divisor tables done");
    wr(REG_CTRL, 32'h0);
    wr(REG_DIV, 32'h4);
    wr(REG_ADDR, 32'(A));
    wr(REG_LEN, 32'h8);
    exp_per = 4;
    load(32'h0);
    chk(32'(user_mode), 32'h1);
    chk(32'(done_oe_n), 32'h1);
    rdc(REG_UCODE, {fb(A), fb(A + 24'h1), fb(A + 24'h2), fb(A + 24'h3)});
    chkd(A);
    $display("test load mode 0 done");
    load(32'h1 << CTRL_WAKE);
    chk(32'(user_mode), 32'h0);
    @(posedge clk);
    pull <= 1'b1;
    tck_pulse(3);
    chk(32'(user_mode), 32'h0);
    tck_pulse(1);
    chk(32'(user_mode), 32'h1);
    $display("test dormant wake done");
    load(32'h1 << CTRL_WAKE);
    chk(32'(user_mode), 32'h1);
    load(32'h1 << CTRL_BYPASS);
    chk(32'(done_oe_n), 32'h0);
    chk(32'(done_out), 32'h0);
    $display("test mode 1 and bypass done");
    @(posedge clk);
    rst();
    exp_per = 100;
    wr(REG_LEN, 32'h8);
    load((32'h1 << CTRL_POR) | (32'h1 << CTRL_SECURE));
    chk(32'(nclr), 32'(CFG_WORDS));
    chk(32'(io_hold), 32'h0);
    chkd(24'h0);
    chk(32'(jtag_gpio), 32'h1);
    wr(REG_CTRL, 32'h1);
    repeat (2) @(posedge clk);
    rdt(REG_STATUS);
    chk(rd & 32'h41, 32'h40);
    $display("test clear and secure done");
    report_and_stop();
  end
endmodule
